// >>> ivwm_top.sv
/*
 * Maps peripheral requests onto 32 lines, arbitrates by software level and
 * line number, issues vectors and handles low-power wakeup.
 * Assumes the core pulses the mode-entry and return inputs synchronously.
 */
`default_nettype none
module ivwm_top
    import ivwm_pkg::*;
(
    input wire logic I_MCLK,
    input wire logic I_RST_B,
    input wire ivwm_merged_type I_MERGED,
    input wire logic [31:0] I_LINE_REQ,
    input wire logic [31:0] I_LINE_EN,
    input wire logic [63:0] I_LINE_LVL,
    input wire logic [31:0] I_WAKE_EVENT_SEL,
    input wire logic I_PORT_PAIR_SELECT,
    input wire logic I_LOW_POWER_RUN,
    input wire logic I_ENTER_HALT,
    input wire logic I_ENTER_ACTIVE_HALT,
    input wire logic I_ENTER_IRQ_WAIT,
    input wire logic I_ENTER_EVENT_WAIT,
    input wire logic I_ACK,
    input wire logic I_IRET,
    output logic O_IRQ,
    output logic [4:0] O_IRQ_NUM,
    output logic [23:0] O_VECTOR,
    output logic O_CORE_STOPPED,
    output logic O_LOW_POWER_WAIT,
    output logic O_WAKE_RESUME
);
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [23:0] vec_of(input logic [4:0] n);
        vec_of = VEC_BASE + VEC_STEP * ({19'h0, n} + VEC_SKIP);
    endfunction

    function automatic logic [1:0] lvl_of(input logic [4:0] n);
        lvl_of = I_LINE_LVL[{n, 1'b0} +: 2];
    endfunction

    // ---------------------------------------------------------------
    // request merging
    // ---------------------------------------------------------------
    logic [31:0] req;
    always_comb begin
        req = I_LINE_REQ;
        req[L_TOP] = I_MERGED.gen_timer_a_ovf | I_MERGED.basic_timer_ovf;
        req[L_CLKALM] = I_MERGED.rtc_alarm
            | I_MERGED.low_speed_crystal_fail;
        req[L_SUPPLY] = I_MERGED.supply_monitor
            | (I_PORT_PAIR_SELECT ? I_MERGED.port_f : I_MERGED.port_e);
        req[L_CLKSYS] = I_MERGED.clk_switch | I_MERGED.clock_failure_detector
            | I_MERGED.advanced_timer_break | I_MERGED.converter;
        req[L_ANALOG] = I_MERGED.comparator_one | I_MERGED.comparator_two
            | I_MERGED.analog_sampler;
        req[L_I2C] = I_LINE_REQ[L_I2C] | I_MERGED.i2c;
    end

    // ---------------------------------------------------------------
    // arbitration
    // ---------------------------------------------------------------
    ivwm_state_type state_reg;
    logic [1:0] cur_lvl_reg;
    logic [1:0] saved_lvl_reg;
    logic [31:0] pend;
    logic found;
    logic [4:0] win;
    logic [1:0] win_lvl;
    logic [31:0] wake_mask;
    logic wake_int;
    logic wake_evt;
    logic [5:0] stack_reg;
    logic evw_go;

    assign pend = req & I_LINE_EN & ~I_WAKE_EVENT_SEL;
    always_comb begin
        found = 1'b0;
        win = 5'h0;
        win_lvl = LVL_IDLE;
        // lowest number wins only when strictly higher level not found
        for (int i = 0; i < NLINES; i++) begin
            if (pend[i] && (lvl_of(5'(i)) > win_lvl || !found)
                && lvl_of(5'(i)) != LVL_IDLE) begin
                if (!found || lvl_of(5'(i)) > win_lvl) begin
                    found = 1'b1;
                    win = 5'(i);
                    win_lvl = lvl_of(5'(i));
                end
            end
        end
    end

    always_comb begin
        unique case (state_reg)
            ST_HALT, ST_AHALT: wake_mask = WAKE_HALT;
            ST_IRQW: wake_mask = WAKE_IRQW;
            ST_EVW: wake_mask = WAKE_EVW;
            default: wake_mask = 32'h0;
        endcase
        // line zero sits in no mask, so the top level never wakes
        // i2c may only wake a halt mode on an own-address match
        if ((state_reg == ST_HALT || state_reg == ST_AHALT)
            && !I_MERGED.i2c_addr_match)
            wake_mask[L_I2C] = 1'b0;
    end
    assign wake_int = |(pend & wake_mask);
    assign wake_evt = (state_reg == ST_EVW)
        && |(req & I_WAKE_EVENT_SEL & WAKE_EVW);

    // ---------------------------------------------------------------
    // power state
    // ---------------------------------------------------------------
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state_reg <= ST_RUN;
        end else begin
            unique case (state_reg)
                ST_RUN: begin
                    if (I_ENTER_HALT)
                        state_reg <= ST_HALT;
                    else if (I_ENTER_ACTIVE_HALT)
                        state_reg <= ST_AHALT;
                    else if (I_ENTER_IRQ_WAIT)
                        state_reg <= ST_IRQW;
                    else if (I_ENTER_EVENT_WAIT)
                        state_reg <= ST_EVW;
                end
                ST_HALT, ST_AHALT, ST_IRQW: begin
                    if (wake_int)
                        state_reg <= ST_RUN;
                end
                ST_EVW: begin
                    if (wake_evt)
                        state_reg <= ST_RUN;
                    else if (wake_int)
                        state_reg <= ST_EVW_SERVE;
                end
                ST_EVW_SERVE: begin
                    // back to sleep once the stack pops to the entry level
                    if (I_IRET && stack_reg[1:0] == saved_lvl_reg)
                        state_reg <= ST_EVW;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // nesting: one level per preemption, a small stack of depth 3
    // ---------------------------------------------------------------
    // stack depth covers the three software levels above idle
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            cur_lvl_reg <= LVL_IDLE;
            stack_reg <= 6'h0;
        end else begin
            if (I_ACK && O_IRQ) begin
                stack_reg <= {stack_reg[3:0], cur_lvl_reg};
                cur_lvl_reg <= win_lvl;
            end else if (I_IRET) begin
                cur_lvl_reg <= stack_reg[1:0];
                stack_reg <= {2'h0, stack_reg[5:2]};
            end
        end
    end

    // ---------------------------------------------------------------
    // event-wait entry level
    // ---------------------------------------------------------------
    // captured while asleep so a nested handler cannot end the service
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            saved_lvl_reg <= LVL_IDLE;
        end else if (state_reg == ST_EVW) begin
            saved_lvl_reg <= cur_lvl_reg;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    logic sleeping;
    assign sleeping = state_reg == ST_HALT || state_reg == ST_AHALT
        || state_reg == ST_IRQW || state_reg == ST_EVW;

    // a higher-priority entry pulse in the same cycle wins over event wait
    assign evw_go = state_reg == ST_RUN && I_ENTER_EVENT_WAIT
        && !I_ENTER_HALT && !I_ENTER_ACTIVE_HALT && !I_ENTER_IRQ_WAIT;

    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_IRQ <= 1'b0;
            O_IRQ_NUM <= 5'h0;
            O_VECTOR <= VEC_BASE;
        end else begin
            // only a strictly higher level preempts a running handler
            O_IRQ <= found && win_lvl > cur_lvl_reg && !sleeping
                && !(I_ACK && O_IRQ);
            O_IRQ_NUM <= win;
            O_VECTOR <= vec_of(win);
        end
    end

    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_CORE_STOPPED <= 1'b0;
            O_LOW_POWER_WAIT <= 1'b0;
            O_WAKE_RESUME <= 1'b0;
        end else begin
            O_CORE_STOPPED <= sleeping;
            if (evw_go)
                O_LOW_POWER_WAIT <= I_LOW_POWER_RUN;
            else if (state_reg == ST_RUN)
                O_LOW_POWER_WAIT <= 1'b0;
            // one-cycle pulse: the state has left event wait by the next edge
            O_WAKE_RESUME <= state_reg == ST_EVW && wake_evt;
        end
    end
endmodule
`default_nettype wire

// >>> ivwm_pkg.sv
/*
 * Constants and types for the interrupt vector map and wakeup logic.
 * Assumes one system clock and active-low asynchronous reset.
 */
// Behaviour
// - each line takes one of three software levels; higher level preempts.
// - thirty-two vectors; lowest line number wins ties at equal level.
// - line zero is top-level irq at 0x008008, never wakes the core.
// - top-level irq is general timer A OR basic timer overflow.
// - event_wait while in low-power run enters low-power wait.
// - in event_wait, a wakeable line is served only if enabled.
// - after serving it in event_wait the core returns to event_wait.
// - a source set as wakeup event wakes event_wait without vectoring.
// - supply monitor ORs with port E/F on line five, 0x00801C, all modes.
// - port_pair_select picks port E or port F for line five.
// - I2C wakes halt modes only on own-address match.
// - line four merges clock alarm and crystal failure, 0x008018, all modes.
// - line six at 0x008020, lines 8..15 up to 0x008044, wake all modes.
// - line seventeen merges four sources, 0x00804C, wakes waits not halts.
// - line eighteen merges comparators and sampler, 0x008050, wakes halts.
`default_nettype none
package ivwm_pkg;
    localparam int NLINES = 32;
    localparam logic [23:0] VEC_BASE = 24'h008000;
    localparam logic [23:0] VEC_STEP = 24'h000004;
    localparam logic [23:0] VEC_SKIP = 24'h000002;
    localparam logic [1:0] LVL_LOW = 2'h1;
    localparam logic [1:0] LVL_IDLE = 2'h0;
    // wake masks per mode, bit n = line n
    localparam logic [31:0] WAKE_HALT = 32'h2404_fff0;
    localparam logic [31:0] WAKE_IRQW = 32'h3e7f_fffe;
    localparam logic [31:0] WAKE_EVW = 32'h3fff_fffe;
    localparam int L_TOP = 0;
    localparam int L_CLKALM = 4;
    localparam int L_SUPPLY = 5;
    localparam int L_CLKSYS = 17;
    localparam int L_ANALOG = 18;
    localparam int L_I2C = 29;

    typedef enum logic [2:0] {
        ST_RUN, ST_HALT, ST_AHALT, ST_IRQW, ST_EVW, ST_EVW_SERVE
    } ivwm_state_type;

    typedef struct packed {
        logic gen_timer_a_ovf;
        logic basic_timer_ovf;
        logic rtc_alarm;
        logic low_speed_crystal_fail;
        logic supply_monitor;
        logic port_e;
        logic port_f;
        logic clk_switch;
        logic clock_failure_detector;
        logic advanced_timer_break;
        logic converter;
        logic comparator_one;
        logic comparator_two;
        logic analog_sampler;
        logic i2c;
        logic i2c_addr_match;
    } ivwm_merged_type;
endpackage
`default_nettype wire

// >>> ivwm_properties.sv
/* Checker for the vector map and wakeup block.
   Bound to ivwm_top; sees its ports only. */
`default_nettype none
module ivwm_properties
    import ivwm_pkg::*;
(
    input wire logic I_MCLK,
    input wire logic I_RST_B,
    input wire ivwm_merged_type I_MERGED,
    input wire logic [31:0] I_LINE_REQ,
    input wire logic [31:0] I_LINE_EN,
    input wire logic [63:0] I_LINE_LVL,
    input wire logic [31:0] I_WAKE_EVENT_SEL,
    input wire logic I_LOW_POWER_RUN,
    input wire logic I_ENTER_HALT,
    input wire logic I_ENTER_ACTIVE_HALT,
    input wire logic I_ENTER_IRQ_WAIT,
    input wire logic I_ENTER_EVENT_WAIT,
    input wire logic I_ACK,
    input wire logic O_IRQ,
    input wire logic [4:0] O_IRQ_NUM,
    input wire logic [23:0] O_VECTOR,
    input wire logic O_CORE_STOPPED,
    input wire logic O_LOW_POWER_WAIT,
    input wire logic O_WAKE_RESUME
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_B);
    // ---------------------------------------------
    // request and wakeup relations
    // ---------------------------------------------
    sequence s_taken;
        O_IRQ && I_ACK;
    endsequence
    sequence s_evw_go;
        !O_CORE_STOPPED && !O_IRQ && I_ENTER_EVENT_WAIT && I_LOW_POWER_RUN
        && !I_ENTER_HALT && !I_ENTER_ACTIVE_HALT && !I_ENTER_IRQ_WAIT;
    endsequence
    AST_VECTOR:
        assert property (O_IRQ |-> O_VECTOR == VEC_BASE + VEC_STEP *
            (24'(O_IRQ_NUM) + VEC_SKIP)) else $error("bad vector");
    AST_ACK_DROP:
        assert property (s_taken |=> !O_IRQ) else $error("irq held");
    AST_EN_GATE:
        assert property (O_IRQ |-> (($past(I_LINE_EN) >> O_IRQ_NUM)
            & 32'h1) == 32'h1) else $error("disabled line");
    AST_LVL_GATE:
        assert property (O_IRQ |-> (($past(I_LINE_LVL) >>
            {O_IRQ_NUM, 1'b0}) & 64'h3) != 64'h0) else $error("level 0");
    AST_EVSEL_GATE:
        assert property (O_IRQ |-> (($past(I_WAKE_EVENT_SEL) >> O_IRQ_NUM)
            & 32'h1) == 32'h0) else $error("event line vectored");
    AST_TOP_NO_WAKE:
        assert property (O_CORE_STOPPED && I_LINE_REQ == 32'h0
            && I_MERGED[13:0] == 14'h0 |=> O_CORE_STOPPED)
        else $error("woken");
    AST_EVW_ENTRY:
        assert property (s_evw_go |=> O_LOW_POWER_WAIT ##1 O_CORE_STOPPED)
        else $error("no low-power wait");
    AST_WAKE_PULSE:
        assert property (O_WAKE_RESUME |-> $past(O_CORE_STOPPED)
            ##1 !O_WAKE_RESUME) else $error("bad wake pulse");
endmodule
bind ivwm_top ivwm_properties ivwm_properties_inst (.*);
`default_nettype wire

// >>> ivwm_core_model.sv
/* Core-side model: takes vectors, returns from handlers.
   Drives on the falling clock edge, as the bench does. */
`default_nettype none
module ivwm_core_model (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_irq,
    input wire logic [23:0] i_vector,
    input wire logic i_slow,
    input wire logic i_hold,
    output logic o_ack,
    output logic o_iret,
    output logic [23:0] o_last_vec,
    output logic [7:0] o_taken
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wait_reg;
    logic [1:0] depth_reg;
    // hold keeps handlers open so nesting can build up
    always_ff @(negedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            {o_ack, o_iret, wait_reg, depth_reg} <= 5'h00;
            o_last_vec <= 24'h000000;
            o_taken <= 8'h00;
        end else begin
            o_ack <= 1'b0;
            o_iret <= 1'b0;
            wait_reg <= i_irq && i_slow && !wait_reg;
            if (i_irq && !o_ack && (!i_slow || wait_reg)) begin
                o_ack <= 1'b1;
                o_last_vec <= i_vector;
                o_taken <= o_taken + 8'h01;
                depth_reg <= depth_reg + 2'h1;
            end else if (depth_reg != 2'h0 && !o_iret && !i_hold) begin
                o_iret <= 1'b1;
                depth_reg <= depth_reg - 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench.sv
/* Bench for ivwm_top with the core model on its vector side.
   Needs ivwm_pkg, ivwm_top, the model and the checker. */
`default_nettype none
`define CHK(a, e, m) begin checks_done++; if ((a) !== (e)) begin \
n_fail++; $display("wrong value at %0t: %s", $time, m); end end
module testbench
    import ivwm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, pps, lpr, e_h, e_ah, e_iw, e_ew, slow, hold;
    logic ack, iret, irq, stop, lpw, wres;
    logic [31:0] req, en, evsel;
    logic [63:0] lvl;
    logic [4:0] num;
    logic [23:0] vec, last;
    logic [7:0] taken;
    ivwm_merged_type mg;
    int n_fail, checks_done, cyc;
    ivwm_top ivwm_top_inst (.I_MCLK(clk), .I_RST_B(rst_b), .I_MERGED(mg),
        .I_LINE_REQ(req), .I_LINE_EN(en), .I_LINE_LVL(lvl),
        .I_WAKE_EVENT_SEL(evsel), .I_PORT_PAIR_SELECT(pps),
        .I_LOW_POWER_RUN(lpr), .I_ENTER_HALT(e_h),
        .I_ENTER_ACTIVE_HALT(e_ah), .I_ENTER_IRQ_WAIT(e_iw),
        .I_ENTER_EVENT_WAIT(e_ew), .I_ACK(ack), .I_IRET(iret),
        .O_IRQ(irq), .O_IRQ_NUM(num), .O_VECTOR(vec),
        .O_CORE_STOPPED(stop), .O_LOW_POWER_WAIT(lpw), .O_WAKE_RESUME(wres));
    ivwm_core_model ivwm_core_model_inst (.i_clk(clk), .i_rst_b(rst_b),
        .i_irq(irq), .i_vector(vec), .i_slow(slow), .i_hold(hold),
        .o_ack(ack), .o_iret(iret), .o_last_vec(last), .o_taken(taken));
    // ---------------------------------------------
    // helpers and scenarios
    // ---------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic serve(input int line, input string m);
        logic [7:0] t0;
        t0 = taken;
        repeat (12) if (taken === t0) @(negedge clk);
        `CHK(taken, t0 + 8'h01, m)
        `CHK(last, VEC_BASE + 24'(4 * (line + 2)), m)
        {req, mg} = '0;
        repeat (4) @(negedge clk);
    endtask
    task automatic quiet(input string m);
        logic [7:0] t0;
        t0 = taken;
        repeat (10) @(negedge clk);
        `CHK(taken, t0, m)
        {req, mg} = '0;
    endtask
    task automatic go(input int k);
        {e_h, e_ah, e_iw, e_ew} = 4'h8 >> k;
        @(negedge clk);
        {e_h, e_ah, e_iw, e_ew} = 4'h0;
        @(negedge clk);
    endtask
    task automatic t_map();
        int lines[15];
        lines = '{0, 0, 4, 4, 5, 5, 5, 17, 17, 17, 17, 18, 18, 18, 29};
        for (int n = 6; n <= 15; n++) begin
            req[n] = 1'b1;
            serve(n, "line");
        end
        slow = 1'b1;
        for (int b = 15; b >= 1; b--) begin
            pps = (b == 9);
            mg[b] = 1'b1;
            serve(lines[15 - b], "merge");
        end
        {slow, pps, mg.port_e} = 3'b011;
        quiet("port select");
        $display("map done");
    endtask
    task automatic t_prio();
        req[12] = 1'b1;
        req[9] = 1'b1;
        serve(9, "tie");
        {req[12], req[9], lvl[25:24]} = 4'hf;
        serve(12, "level");
        {hold, req[9], lvl[25:24]} = 4'hd;
        serve(9, "first");
        req[10] = 1'b1;
        quiet("same level");
        {lvl[25:24], req[12]} = 3'h5;
        serve(12, "preempt");
        {hold, lvl[25:24]} = 3'h1;
        en[8] = 1'b0;
        req[8] = 1'b1;
        quiet("disabled");
        {en[8], lvl[17:16], req[8]} = 4'h9;
        quiet("level zero");
        {lvl[17:16], evsel[8], req[8]} = 4'h7;
        quiet("event line");
        evsel = '0;
        $display("prio done");
    endtask
    task automatic t_sleep();
        go(0);
        mg.gen_timer_a_ovf = 1'b1;
        quiet("top level");
        mg.clk_switch = 1'b1;
        quiet("switch in halt");
        mg.i2c = 1'b1;
        quiet("no match");
        `CHK(stop, 1'b1, "asleep")
        {mg.i2c, mg.i2c_addr_match} = 2'b11;
        serve(29, "match");
        `CHK(stop, 1'b0, "awake")
        go(2);
        mg.clk_switch = 1'b1;
        serve(17, "irq wait");
        go(1);
        mg.comparator_one = 1'b1;
        serve(18, "active halt");
        go(0);
        mg.rtc_alarm = 1'b1;
        serve(4, "alarm");
        go(0);
        req[7] = 1'b1;
        serve(7, "line 7 halt");
        lpr = 1'b1;
        go(3);
        `CHK(lpw, 1'b1, "low power wait")
        req[8] = 1'b1;
        serve(8, "event wait");
        `CHK(stop, 1'b1, "back asleep")
        {evsel[9], req[9]} = 2'b11;
        repeat (10) if (wres !== 1'b1) @(negedge clk);
        `CHK(wres, 1'b1, "wake event")
        quiet("not vectored");
        `CHK(stop, 1'b0, "resumed")
        $display("sleep done");
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            final_report();
        end
    end
    initial begin
        {rst_b, pps, lpr, e_h, e_ah, e_iw, e_ew, slow, hold} = 9'h000;
        {mg, req, evsel} = '0;
        en = '1;
        lvl = {32{2'h1}};
        repeat (2) @(negedge clk);
        `CHK(vec, VEC_BASE, "reset vector")
        rst_b = 1'b1;
        @(negedge clk);
        t_map();
        t_prio();
        t_sleep();
        final_report();
    end
endmodule
`default_nettype wire
